// ==== uvbp_boost_pwm.sv ====
// Top of the VBUS boost PWM controller: PWM generation, target select and comparators.
// Assumes control words come from logic on clk; comparator inputs are asynchronous pins.
//
// What this block does
// - The PWM period is the low byte and the duty the high byte of the period/duty word.
// - Control bit 9 sets the active level of the PWM output.
// - OTG control bit 1 selects the VBUS target voltage that is regulated.
// - Control bit 8 set to one runs the PWM counter.
// - Control bit 15 set to one enables the PWM output.
// - OTG control bit 3 set to one enables the VBUS generation circuit.
// - In host role, with generation enabled and no over-current, VBUS is supplied to the attached device.
// - The PWM output drives an external switcher that makes the 5V VBUS.
// - Comparators watch VBUS and limit the boost supply current.
`timescale 1ns/10ps
`default_nettype none
module uvbp_boost_pwm #(
   parameter int W = uvbp_pkg::BYTE_W
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [15:0] boostPeriodDutyReg,
   input  wire logic [15:0] boostPwmControlReg,
   input  wire logic [15:0] otgControlReg,
   input  wire logic [15:0] usbModulePowerCtl,
   input  wire logic        hostRole,
   input  wire logic        vbusAboveTarget,
   input  wire logic        overCurrent,
   output logic             boostPwmOut,
   output logic             vbusTargetHigh,
   output logic             vbusSupplyEn,
   output logic             genReady,
   output logic             currentLimited
);
   logic [W-1:0] periodVal;
   logic [W-1:0] dutyVal;
   logic         polarity;
   logic         counterEn;
   logic         boost_pwm_enable;
   logic         genEn;
   logic [W-1:0] count;
   logic         wrap;
   logic [1:0]   aboveSync_r;
   logic [1:0]   ocSync_r;
   logic         pwmActive;

   assign periodVal = boostPeriodDutyReg[uvbp_pkg::PERIOD_LSB +: W];
   assign dutyVal   = boostPeriodDutyReg[uvbp_pkg::DUTY_LSB +: W];
   assign polarity  = boostPwmControlReg[uvbp_pkg::CTL_POL_BIT];
   assign counterEn = boostPwmControlReg[uvbp_pkg::CTL_BOOST_COUNTER_ENABLE_BIT];
   assign boost_pwm_enable     = boostPwmControlReg[uvbp_pkg::CTL_BOOST_PWM_ENABLE_BIT];
   assign genEn     = otgControlReg[uvbp_pkg::OTG_GEN_BIT];

   uvbp_counter #(.W(W)) uCounter (
      .clk    (clk),
      .rst    (rst),
      .run    (counterEn),
      .period (periodVal),
      .count  (count),
      .wrap   (wrap)
   );

   // Comparator pins are two-stage synchronised.
   always_ff @(posedge clk) begin
      if (rst) begin
         aboveSync_r <= 2'h0;
         ocSync_r    <= 2'h0;
      end else begin
         aboveSync_r <= {aboveSync_r[0], vbusAboveTarget};
         ocSync_r    <= {ocSync_r[0], overCurrent};
      end
   end

   assign pwmActive = counterEn && boost_pwm_enable && genEn && !aboveSync_r[1] && !ocSync_r[1]
                      && (count < dutyVal);

   always_ff @(posedge clk) begin
      if (rst) begin
         boostPwmOut <= 1'b0;
      end else if (boost_pwm_enable) begin
         boostPwmOut <= pwmActive ^ ~polarity;
      end else begin
         boostPwmOut <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         vbusTargetHigh <= 1'b0;
      end else begin
         vbusTargetHigh <= otgControlReg[uvbp_pkg::OTG_TARGET_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         vbusSupplyEn <= 1'b0;
      end else begin
         vbusSupplyEn <= genEn && hostRole && !ocSync_r[1];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         genReady <= 1'b0;
      end else begin
         genReady <= usbModulePowerCtl[uvbp_pkg::PWR_ON_BIT]
                     && !otgControlReg[uvbp_pkg::OTG_DISCH_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         currentLimited <= 1'b0;
      end else begin
         currentLimited <= ocSync_r[1];
      end
   end

   chk_pwm_off_disabled: assert property (@(posedge clk) disable iff (rst)
      !boost_pwm_enable |=> boostPwmOut == 1'b0)
      else $error("PWM output moved while disabled.");
   chk_active_level: assert property (@(posedge clk) disable iff (rst)
      boost_pwm_enable |=> boostPwmOut == ($past(pwmActive) ^ ~$past(polarity)))
      else $error("PWM output level wrong for polarity.");
   chk_duty_compare: assert property (@(posedge clk) disable iff (rst)
      pwmActive |-> count < dutyVal)
      else $error("Active phase beyond duty.");
   chk_counter_idle: assert property (@(posedge clk) disable iff (rst)
      !counterEn ##1 !counterEn |-> count == '0)
      else $error("Counter ran while disabled.");
   chk_target_follow: assert property (@(posedge clk) disable iff (rst)
      ##1 vbusTargetHigh == $past(otgControlReg[uvbp_pkg::OTG_TARGET_BIT]))
      else $error("Target select not followed.");
   chk_gen_enable: assert property (@(posedge clk) disable iff (rst)
      !genEn |=> !vbusSupplyEn)
      else $error("VBUS supplied while generation disabled.");
   chk_host_supply: assert property (@(posedge clk) disable iff (rst)
      genEn && hostRole && !ocSync_r[1] |=> vbusSupplyEn)
      else $error("Host role without VBUS supply.");
   chk_overcurrent_stop: assert property (@(posedge clk) disable iff (rst)
      overCurrent [*3] |=> !pwmActive && currentLimited)
      else $error("Over-current did not stop switching.");
   chk_ready_flag: assert property (@(posedge clk) disable iff (rst)
      ##1 genReady == ($past(usbModulePowerCtl[uvbp_pkg::PWR_ON_BIT])
                       && !$past(otgControlReg[uvbp_pkg::OTG_DISCH_BIT])))
      else $error("Readiness flag wrong.");
   chk_wrap_unused: assert property (@(posedge clk) disable iff (rst)
      counterEn && $past(counterEn) |-> count <= periodVal || $past(count) > periodVal
      || periodVal != $past(periodVal))
      else $error("Count passed period.");


   // The guards below pin down the gating order of the switching path.
   // Each enable bit and each synchronised comparator must be able to
   // stop the active phase on its own, so that a stuck bit in one of
   // them cannot keep the external switch on.
   // The status outputs must also drop with reset, whatever the inputs.

   chk_wrap_restart: assert property (@(posedge clk) disable iff (rst)
      wrap |=> count == '0)
      else $error("Counter did not restart after wrap.");

   chk_count_start: assert property (@(posedge clk) disable iff (rst)
      $rose(counterEn) |-> count == '0)
      else $error("Counter did not start from zero.");

   chk_counter_gate: assert property (@(posedge clk) disable iff (rst)
      !counterEn |-> !pwmActive)
      else $error("Switching with counter stopped.");

   chk_gen_gate: assert property (@(posedge clk) disable iff (rst)
      !genEn |-> !pwmActive)
      else $error("Switching with generation disabled.");

   chk_reset_quiet: assert property (@(posedge clk)
      rst |=> boostPwmOut == 1'b0 && vbusSupplyEn == 1'b0 && genReady == 1'b0
      && currentLimited == 1'b0 && vbusTargetHigh == 1'b0)
      else $error("Outputs not quiet after reset.");

   chk_host_drop: assert property (@(posedge clk) disable iff (rst)
      !hostRole |=> !vbusSupplyEn)
      else $error("VBUS supplied outside host role.");

   chk_oc_supply: assert property (@(posedge clk) disable iff (rst)
      ocSync_r[1] |=> !vbusSupplyEn)
      else $error("VBUS supplied during over-current.");

   chk_limit_follow: assert property (@(posedge clk) disable iff (rst)
      ##1 currentLimited == $past(ocSync_r[1]))
      else $error("Current limit status not followed.");

   chk_limit_clear: assert property (@(posedge clk) disable iff (rst)
      !ocSync_r[1] |=> !currentLimited)
      else $error("Current limit status stuck.");

   chk_regulate_stop: assert property (@(posedge clk) disable iff (rst)
      aboveSync_r[1] |-> !pwmActive)
      else $error("Switching while VBUS above target.");

   chk_sync_order: assert property (@(posedge clk) disable iff (rst)
      ##1 aboveSync_r[1] == $past(aboveSync_r[0]))
      else $error("Comparator synchroniser out of order.");

   chk_ready_off: assert property (@(posedge clk) disable iff (rst)
      !usbModulePowerCtl[uvbp_pkg::PWR_ON_BIT] |=> !genReady)
      else $error("Ready shown with module unpowered.");

   cov_pwm_toggle: cover property (@(posedge clk) disable iff (rst)
      pwmActive ##1 !pwmActive);
   cov_supply_on:  cover property (@(posedge clk) disable iff (rst) vbusSupplyEn);
   cov_limit:      cover property (@(posedge clk) disable iff (rst) currentLimited);
   cov_wrap:       cover property (@(posedge clk) disable iff (rst) wrap);
   cov_regulate:   cover property (@(posedge clk) disable iff (rst)
      aboveSync_r[1] && boost_pwm_enable);
endmodule
`default_nettype wire

// ==== uvbp_pkg.sv ====
// Package for the VBUS boost PWM controller: register field positions and reset values.
// Assumes a single 250 MHz clock domain and plain-port control bits.
package uvbp_pkg;
   localparam int          PERIOD_LSB     = 0;
   localparam int          DUTY_LSB       = 8;
   localparam int          BYTE_W         = 8;
   localparam int          CTL_BOOST_COUNTER_ENABLE_BIT  = 8;
   localparam int          CTL_POL_BIT    = 9;
   localparam int          CTL_BOOST_PWM_ENABLE_BIT  = 15;
   localparam int          OTG_DISCH_BIT  = 0;
   localparam int          OTG_TARGET_BIT = 1;
   localparam int          OTG_GEN_BIT    = 3;
   localparam int          PWR_ON_BIT     = 0;
   localparam logic [15:0] RESET_WORD     = 16'h0000;
   localparam int          CLK_MHZ        = 250;
endpackage

// ==== uvbp_counter.sv ====
// Period counter for the boost PWM, held at zero while run is low.
// Assumes synchronous active-high reset on the same clock as its user.
`timescale 1ns/10ps
`default_nettype none
module uvbp_counter #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         run,
   input  wire logic [W-1:0] period,
   output logic      [W-1:0] count,
   output logic              wrap
);
   assign wrap = run && (count >= period);

   always_ff @(posedge clk) begin
      if (rst || !run) begin
         count <= '0;
      end else if (wrap) begin
         count <= '0;
      end else begin
         count <= count + W'(1);
      end
   end

   chk_count_bounded: assert property (@(posedge clk) disable iff (rst)
      run && $past(run) && $past(count) < $past(period) && period == $past(period)
      |-> count == $past(count) + W'(1))
      else $error("Counter did not advance by one.");
endmodule
`default_nettype wire

// ==== uvbp_smps_model.sv ====
// Switch-mode supply model that builds VBUS from the boost PWM.
// Assumes it shares the clock of the boost block.
`timescale 1ns/10ps
`default_nettype none
module uvbp_smps_model #(
   parameter int TARGET = 40
) (
   input  wire logic clk,
   input  wire logic pwm,
   input  wire logic activeHigh,
   input  wire logic supplyEn,
   input  wire logic heavyLoad,
   input  wire logic shortOut,
   output logic      vbusAboveTarget,
   output logic      overCurrent
);
   int level = 0;
   always_ff @(posedge clk) begin
      if (heavyLoad) level <= 0;
      else if (supplyEn && pwm == activeHigh) level <= level + 2;
      else if (level > 0) level <= level - 1;
   end
   assign vbusAboveTarget = (level >= TARGET);
   assign overCurrent     = shortOut;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the boost PWM block against an integer model.
// Assumes the supply model sits on the PWM pin and drives the comparators.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clk = 0, rst = 1, host = 0, heavy = 1, shortOut = 0, pol = 1;
   logic [15:0] pd = 16'h0000, ctl = 16'h0000, otg = 16'h0000, pwr = 16'h0000;
   logic        pwmOut, tgtHigh, supEn, ready, limited, above, oc;
   int          fails = 0, cmp_count = 0, act, per, duty;
   uvbp_boost_pwm DUT (.clk(clk), .rst(rst), .boostPeriodDutyReg(pd),
      .boostPwmControlReg(ctl), .otgControlReg(otg), .usbModulePowerCtl(pwr),
      .hostRole(host), .vbusAboveTarget(above), .overCurrent(oc), .boostPwmOut(pwmOut),
      .vbusTargetHigh(tgtHigh), .vbusSupplyEn(supEn), .genReady(ready),
      .currentLimited(limited));
   uvbp_smps_model smps (.clk(clk), .pwm(pwmOut), .activeHigh(pol), .supplyEn(supEn),
      .heavyLoad(heavy), .shortOut(shortOut), .vbusAboveTarget(above), .overCurrent(oc));
   initial begin
      forever #2 clk = ~clk;
   end
   task check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Counts cycles in which the output sits at its active level.
   task measure(input int n);
      act = 0;
      repeat (n) begin
         cyc(1);
         if (pwmOut === pol) act++;
      end
   endtask
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      test_done;
   end
   initial begin
      void'($urandom(31083));
      cyc(2);
      rst = 0;
      cyc(1);
      check(16'({pwmOut, tgtHigh, supEn, ready, limited}), 16'h0000);
      for (int i = 0; i < 4; i++) begin
         pwr[0] = i[0];
         otg[0] = i[1];
         cyc(2);
         check(16'(ready), 16'(i == 1));
      end
      otg[0] = 1'b0;
      for (int k = 0; k < 6; k++) begin
         // all enables set together, before the same clock edge.
         per = 1 + ($urandom % 50);
         duty = $urandom % (per + 5);
         pol = k[0];
         pd = {duty[7:0], per[7:0]};
         ctl[9] = pol;
         otg[1] = k[1];
         ctl[8] = 1'b1;
         ctl[15] = 1'b1;
         otg[3] = 1'b1;
         host = 1'b1;
         cyc(2);
         check(16'(tgtHigh), 16'(k[1]));
         check(16'(supEn), 16'h0001);
         cyc(per + 4);
         measure(4 * (per + 1));
         check(16'(act), 16'(4 * ((duty > per + 1) ? per + 1 : duty)));
      end
      pol = 1'b1;
      ctl[9] = 1'b1;
      for (int j = 0; j < 3; j++) begin
         ctl[8] = (j != 0);
         ctl[15] = (j != 1);
         otg[3] = (j != 2);
         cyc(3);
         measure(60);
         check(16'(act), 16'h0000);
      end
      otg[3] = 1'b1;
      shortOut = 1'b1;
      cyc(4);
      check(16'({limited, supEn}), 16'h0002);
      measure(40);
      check(16'(act), 16'h0000);
      shortOut = 1'b0;
      heavy = 1'b0;
      pd = 16'h0509;
      cyc(300);
      measure(100);
      check(16'(act < 50), 16'h0001);
      host = 1'b0;
      cyc(2);
      check(16'(supEn), 16'h0000);
      test_done;
   end
endmodule
`default_nettype wire
